// File: design/sbb_pkg.sv
// Shared types and constants for the system bus bridge
// Notes on behaviour
// R1 - Local and system sides run on unrelated clocks; all crossings are handshakes.
// R2 - Each entry holds 32 data, 32 address and 10 control bits: 74 bits.
// R3 - One entry per direction; a second local access or system read waits while the entry is full.
// R4 - Local writes are posted, local transfer ends, system write happens later.
// R5 - A system error on a posted write is returned as a data abort.
// R6 - Local transactions reach the system bus in presentation order.
// R7 - Local reads wait until the system read ends, then get data and error.
// R8 - System writes to SDRAM are taken in one cycle when the entry is free.
// R9 - System writes arriving at a full entry get a retract answer.
// R10 - A retracted system master drops the attempt and retries later.
// R11 - System reads pass address and control through the entry; data bypasses it.
// R12 - Queued SDRAM writes finish before a system read of SDRAM is done.
// R13 - Outbound and inbound paths run independently and at the same time.
// R14 - An entry stays valid until its transfer and response have completed.
package sbb_pkg;
   localparam int unsigned SBB_DW = 32;
   localparam int unsigned SBB_AW = 32;
   localparam int unsigned SBB_CW = 10;
   localparam int unsigned SBB_ENTRY_W = SBB_DW + SBB_AW + SBB_CW;
   localparam logic [SBB_CW-1:0] SBB_CTRL_RST = 10'h000;
   localparam logic SBB_CTRL_WRITE_BIT_RST = 1'b0;

   // R2 one 74-bit bridged entry
   typedef struct packed {
      logic [SBB_CW-1:0] ctrl;
      logic [SBB_AW-1:0] addr;
      logic [SBB_DW-1:0] data;
   } sbb_entry_s;

   // Response carried back across the boundary
   typedef struct packed {
      logic [SBB_DW-1:0] rdata;
      logic err;
   } sbb_resp_s;

   // Outbound state in the local domain
   typedef struct packed {
      logic full;
      logic is_read;
      logic req_tgl;
      logic [2:0] ack_sync;
      logic abort;
      logic done;
      sbb_entry_s ent;
      sbb_resp_s resp;
   } sbb_loc_s;

   // Outbound state in the system domain
   typedef struct packed {
      logic [2:0] req_sync;
      logic busy;
      logic ack_tgl;
      sbb_resp_s resp;
   } sbb_sys_out_s;

   // Inbound state in the system domain
   typedef struct packed {
      logic full;
      logic req_tgl;
      logic [2:0] ack_sync;
      logic rd_wait;
      logic rd_done;
      sbb_entry_s ent;
      logic [SBB_DW-1:0] rdata;
   } sbb_sys_in_s;

   // Inbound state in the local (memory) domain
   typedef struct packed {
      logic [2:0] req_sync;
      logic busy;
      logic ack_tgl;
      logic [SBB_DW-1:0] rdata;
   } sbb_mem_s;
endpackage : sbb_pkg

// File: design/sbb_bridge.sv
// System bus bridge: one-entry outbound and inbound paths across two clocks
`timescale 1ns/1ps
module sbb_bridge
   import sbb_pkg::*;
(
   // Local memory bus clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // System bus clock and reset
   input wire logic sclk_i,
   input wire logic srst_n_i,
   // Local processor request toward the system bus
   input wire logic cpu_req_i,
   input wire logic cpu_write_i,
   input wire sbb_entry_s cpu_ent_i,
   output logic cpu_ready_o,
   output logic cpu_abort_o,
   output logic [SBB_DW-1:0] cpu_rdata_o,
   // Outbound master on the system bus
   output logic sm_req_o,
   output sbb_entry_s sm_ent_o,
   input wire logic sm_done_i,
   input wire logic sm_err_i,
   input wire logic [SBB_DW-1:0] sm_rdata_i,
   // Inbound slave on the system bus, aimed at local SDRAM
   input wire logic ss_sel_i,
   input wire logic ss_write_i,
   input wire sbb_entry_s ss_ent_i,
   output logic ss_ok_o,
   output logic ss_retract_o,
   output logic ss_rvalid_o,
   output logic [SBB_DW-1:0] ss_rdata_o,
   // SDRAM controller port, local clock
   output logic mem_req_o,
   output sbb_entry_s mem_ent_o,
   input wire logic mem_done_i,
   input wire logic [SBB_DW-1:0] mem_rdata_i
);

   // ---------------- Outbound, local side ----------------
   sbb_loc_s loc;
   sbb_loc_s next_loc;
   sbb_sys_out_s so;
   sbb_sys_out_s next_so;
   sbb_sys_in_s si;
   sbb_sys_in_s next_si;
   sbb_mem_s mm;
   sbb_mem_s next_mm;

   logic loc_ack_edge;
   logic accept_cpu;

   // Ack edge is read only from the second and third stages
   assign loc_ack_edge = loc.ack_sync[2] ^ loc.ack_sync[1];
   // Done cycle still belongs to the finished read, so no retake
   // R3 entry full stalls
   assign accept_cpu = cpu_req_i && !loc.full && !loc.done;

   always_comb begin
      next_loc = loc;
      next_loc.ack_sync = {loc.ack_sync[1:0], so.ack_tgl};
      next_loc.done = 1'b0;
      next_loc.abort = 1'b0;
      // R4 post and end transfer
      if (accept_cpu) begin
         next_loc.full = 1'b1;
         next_loc.is_read = !cpu_write_i;
         next_loc.ent = cpu_ent_i;
         next_loc.req_tgl = !loc.req_tgl;
      end
      // R14 clear after response
      if (loc_ack_edge) begin
         next_loc.full = 1'b0;
         next_loc.resp = so.resp;
         next_loc.done = loc.is_read;
         // R5 write error aborts
         next_loc.abort = so.resp.err;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         loc <= '0;
      end else begin
         loc <= next_loc;
      end
   end

   // R7 wait until read ends
   assign cpu_ready_o = loc.done
                        || (cpu_req_i && cpu_write_i && !loc.full && !loc.done);
   assign cpu_abort_o = loc.abort;
   assign cpu_rdata_o = loc.resp.rdata;

   // ---------------- Outbound, system side ----------------
   logic so_req_edge;

   // R1 toggle handshake crossing
   assign so_req_edge = so.req_sync[2] ^ so.req_sync[1];

   always_comb begin
      next_so = so;
      next_so.req_sync = {so.req_sync[1:0], loc.req_tgl};
      // R6 one at a time, in order
      if (so_req_edge) begin
         next_so.busy = 1'b1;
      end
      if (so.busy && sm_done_i) begin
         next_so.busy = 1'b0;
         next_so.resp.err = sm_err_i;
         next_so.resp.rdata = sm_rdata_i;
         next_so.ack_tgl = !so.ack_tgl;
      end
   end

   always_ff @(posedge sclk_i) begin
      if (!srst_n_i) begin
         so <= '0;
      end else begin
         so <= next_so;
      end
   end

   assign sm_req_o = so.busy;
   // Entry stays stable while the handshake is open
   assign sm_ent_o = loc.ent;

   // ---------------- Inbound, system side ----------------
   logic si_ack_edge;
   logic take_wr;
   logic take_rd;

   assign si_ack_edge = si.ack_sync[2] ^ si.ack_sync[1];
   // R8 single-cycle write accept
   assign take_wr = ss_sel_i && ss_write_i && !si.full;
   // R12 read waits for empty entry
   assign take_rd = ss_sel_i && !ss_write_i && !si.full && !si.rd_wait;

   always_comb begin
      next_si = si;
      next_si.ack_sync = {si.ack_sync[1:0], mm.ack_tgl};
      next_si.rd_done = 1'b0;
      if (take_wr || take_rd) begin
         next_si.full = 1'b1;
         next_si.ent = ss_ent_i;
         next_si.rd_wait = take_rd;
         next_si.req_tgl = !si.req_tgl;
      end
      // R14 clear after SDRAM done
      if (si_ack_edge) begin
         next_si.full = 1'b0;
         next_si.rd_wait = 1'b0;
         next_si.rd_done = si.rd_wait;
         // R11 data bypasses entry
         next_si.rdata = mm.rdata;
      end
   end

   always_ff @(posedge sclk_i) begin
      if (!srst_n_i) begin
         si <= '0;
      end else begin
         si <= next_si;
      end
   end

   assign ss_ok_o = take_wr;
   // Reads behind a queued write wait; only writes are retracted
   // R9 retract on full
   assign ss_retract_o = ss_sel_i && ss_write_i && si.full;
   assign ss_rvalid_o = si.rd_done;
   assign ss_rdata_o = si.rdata;

   // ---------------- Inbound, memory side ----------------
   logic mm_req_edge;

   // R13 independent of outbound path
   assign mm_req_edge = mm.req_sync[2] ^ mm.req_sync[1];

   always_comb begin
      next_mm = mm;
      next_mm.req_sync = {mm.req_sync[1:0], si.req_tgl};
      if (mm_req_edge) begin
         next_mm.busy = 1'b1;
      end
      if (mm.busy && mem_done_i) begin
         next_mm.busy = 1'b0;
         next_mm.rdata = mem_rdata_i;
         next_mm.ack_tgl = !mm.ack_tgl;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         mm <= '0;
      end else begin
         mm <= next_mm;
      end
   end

   assign mem_req_o = mm.busy;
   assign mem_ent_o = si.ent;

   // ---------------- Assertions ----------------
   property p_full_stall;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (loc.full && cpu_write_i && cpu_req_i) |-> !cpu_ready_o;
   endproperty
   a_full_stall: assert property (p_full_stall) else $error("write taken while full"); // R3

   property p_post;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (cpu_req_i && cpu_write_i && !loc.full) |=> (loc.full && loc.ent == $past(cpu_ent_i));
   endproperty
   a_post: assert property (p_post) else $error("write not posted"); // R4

   property p_abort;
      @(posedge mclk_i) disable iff (!rst_n_i)
      loc_ack_edge && so.resp.err |=> cpu_abort_o;
   endproperty
   a_abort: assert property (p_abort) else $error("error not aborted"); // R5

   property p_order;
      @(posedge sclk_i) disable iff (!srst_n_i)
      so.busy |-> !so_req_edge;
   endproperty
   a_order: assert property (p_order) else $error("second request overlaps"); // R6

   property p_read_wait;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (loc.full && loc.is_read) |-> !cpu_ready_o;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read ended early"); // R7

   property p_wr_accept;
      @(posedge sclk_i) disable iff (!srst_n_i)
      (ss_sel_i && ss_write_i && !si.full) |-> ss_ok_o ##1 si.full;
   endproperty
   a_wr_accept: assert property (p_wr_accept) else $error("write not accepted"); // R8

   property p_retract;
      @(posedge sclk_i) disable iff (!srst_n_i)
      (ss_sel_i && ss_write_i && si.full) |-> (ss_retract_o && !ss_ok_o);
   endproperty
   a_retract: assert property (p_retract) else $error("no retract when full"); // R9

   property p_rd_order;
      @(posedge sclk_i) disable iff (!srst_n_i)
      (ss_sel_i && !ss_write_i && si.full) |=> $stable(si.ent);
   endproperty
   a_rd_order: assert property (p_rd_order) else $error("read overtook write"); // R12

   property p_hold;
      @(posedge sclk_i) disable iff (!srst_n_i)
      (si.full && !si_ack_edge) |=> si.full;
   endproperty
   a_hold: assert property (p_hold) else $error("entry dropped early"); // R14

   property p_loc_hold;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (loc.full && !loc_ack_edge) |=> loc.full;
   endproperty
   a_loc_hold: assert property (p_loc_hold) else $error("outbound entry dropped early"); // R14

   property p_no_retake;
      @(posedge mclk_i) disable iff (!rst_n_i)
      loc.done |=> !loc.full;
   endproperty
   a_no_retake: assert property (p_no_retake) else $error("finished read taken again"); // R3

   property p_rd_data;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (loc_ack_edge && loc.is_read) |=> (cpu_ready_o && cpu_rdata_o == $past(so.resp.rdata));
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read data not returned"); // R7

   property p_abort_pulse;
      @(posedge mclk_i) disable iff (!rst_n_i)
      cpu_abort_o |=> !cpu_abort_o;
   endproperty
   a_abort_pulse: assert property (p_abort_pulse) else $error("abort longer than one cycle"); // R5

   property p_sm_stable;
      @(posedge sclk_i) disable iff (!srst_n_i)
      (sm_req_o && !sm_done_i) |=> $stable(sm_ent_o);
   endproperty
   a_sm_stable: assert property (p_sm_stable) else $error("outbound entry moved"); // R1

   property p_sm_hold;
      @(posedge sclk_i) disable iff (!srst_n_i)
      (sm_req_o && !sm_done_i) |=> sm_req_o;
   endproperty
   a_sm_hold: assert property (p_sm_hold) else $error("system request dropped"); // R4

   property p_sm_in_full;
      @(posedge sclk_i) disable iff (!srst_n_i)
      sm_req_o |-> loc.full;
   endproperty
   a_sm_in_full: assert property (p_sm_in_full) else $error("system request without entry"); // R14

   property p_mem_stable;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (mem_req_o && !mem_done_i) |=> $stable(mem_ent_o);
   endproperty
   a_mem_stable: assert property (p_mem_stable) else $error("memory entry moved"); // R11

   property p_mem_hold;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (mem_req_o && !mem_done_i) |=> mem_req_o;
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped"); // R8

   property p_mem_in_full;
      @(posedge mclk_i) disable iff (!rst_n_i)
      mem_req_o |-> si.full;
   endproperty
   a_mem_in_full: assert property (p_mem_in_full) else $error("memory request without entry"); // R12

   property p_rvalid_pulse;
      @(posedge sclk_i) disable iff (!srst_n_i)
      ss_rvalid_o |=> !ss_rvalid_o;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid too long"); // R11

   property p_sys_rd_data;
      @(posedge sclk_i) disable iff (!srst_n_i)
      (si_ack_edge && si.rd_wait) |=> (ss_rvalid_o && ss_rdata_o == $past(mm.rdata));
   endproperty
   a_sys_rd_data: assert property (p_sys_rd_data) else $error("system read data lost"); // R11

   property p_read_no_retract;
      @(posedge sclk_i) disable iff (!srst_n_i)
      (ss_sel_i && !ss_write_i) |-> !ss_retract_o;
   endproperty
   a_read_no_retract: assert property (p_read_no_retract) else $error("read retracted"); // R12

   c_post: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      accept_cpu && cpu_write_i);
   c_read: cover property (@(posedge mclk_i) disable iff (!rst_n_i) loc.done);
   c_retract: cover property (@(posedge sclk_i) disable iff (!srst_n_i) ss_retract_o);
   c_sys_read: cover property (@(posedge sclk_i) disable iff (!srst_n_i) si.rd_done);
   c_wait_read: cover property (@(posedge sclk_i) disable iff (!srst_n_i)
      ss_sel_i && !ss_write_i && si.full && !si.rd_wait);

endmodule : sbb_bridge

// File: verif/sbb_far_model.sv
// Far side model: system bus slave and SDRAM controller
`timescale 1ns/1ps
module sbb_far_model
   import sbb_pkg::*;
(
   // Clocks and modes
   input wire logic sclk_i,
   input wire logic mclk_i,
   input wire logic slow_i,
   input wire logic err_i,
   // System bus slave
   input wire logic sm_req_i,
   input wire sbb_entry_s sm_ent_i,
   output logic sm_done_o = 1'b0,
   output logic sm_err_o = 1'b0,
   output logic [SBB_DW-1:0] sm_rdata_o = 32'h0000_0000,
   // SDRAM controller
   input wire logic mem_req_i,
   input wire sbb_entry_s mem_ent_i,
   output logic mem_done_o = 1'b0,
   output logic [SBB_DW-1:0] mem_rdata_o = 32'h0000_0000
);
   logic [SBB_DW-1:0] mem [0:15];
   logic [3:0] sc = 4'h0;
   logic [3:0] mc = 4'h0;
   logic [SBB_DW-1:0] junk = 32'h5A5A_A5A5;
   // Idle data churns so a stale value never passes
   always @(posedge sclk_i) begin
      junk <= {junk[30:0], junk[31] ^ junk[21]} ^ 32'h0000_0001;
      sm_done_o <= 1'b0;
      sm_rdata_o <= junk;
      if (sm_req_i && !sm_done_o) begin
         if (sc >= (slow_i ? 4'h6 : 4'h0)) begin
            sc <= 4'h0;
            sm_done_o <= 1'b1;
            sm_err_o <= err_i;
            sm_rdata_o <= ~sm_ent_i.addr;
         end else begin
            sc <= sc + 4'h1;
         end
      end
   end
   // Bench encodes write direction in control bit 0
   always @(posedge mclk_i) begin
      mem_done_o <= 1'b0;
      mem_rdata_o <= ~junk;
      if (mem_req_i && !mem_done_o) begin
         if (mc >= (slow_i ? 4'h8 : 4'h1)) begin
            mc <= 4'h0;
            mem_done_o <= 1'b1;
            mem_rdata_o <= mem[mem_ent_i.addr[5:2]];
            if (mem_ent_i.ctrl[0]) begin
               mem[mem_ent_i.addr[5:2]] <= mem_ent_i.data;
            end
         end else begin
            mc <= mc + 4'h1;
         end
      end
   end
endmodule : sbb_far_model

// File: verif/sbb_bridge_test.sv
// Self-checking bench for the system bus bridge
`timescale 1ns/1ps
module sbb_bridge_test;
   import sbb_pkg::*;
   logic mclk_i = 1'b0;
   logic sclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic srst_n_i = 1'b0;
   logic cpu_req = 1'b0, cpu_write = 1'b0, ss_sel = 1'b0, ss_write = 1'b0;
   logic slow = 1'b1, err = 1'b0, sm_prev = 1'b0;
   sbb_entry_s cpu_ent = '0, ss_ent = '0, e, e2;
   logic cpu_ready_o, cpu_abort_o, sm_req_o, sm_done_i, sm_err_i, ss_ok_o, ss_retract_o;
   logic ss_rvalid_o, mem_req_o, mem_done_i;
   logic [SBB_DW-1:0] cpu_rdata_o, sm_rdata_i, ss_rdata_o, mem_rdata_i, d, d2;
   sbb_entry_s sm_ent_o, mem_ent_o;
   sbb_entry_s exp_q[$], got_q[$];
   int n_errors = 0, n_checks = 0, n_abort = 0, seed = 54, n, r, k;
   always #25 mclk_i = ~mclk_i;
   always #32 sclk_i = ~sclk_i;
   sbb_bridge sbb_bridge_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
      .srst_n_i(srst_n_i), .cpu_req_i(cpu_req), .cpu_write_i(cpu_write), .cpu_ent_i(cpu_ent),
      .cpu_ready_o(cpu_ready_o), .cpu_abort_o(cpu_abort_o), .cpu_rdata_o(cpu_rdata_o),
      .sm_req_o(sm_req_o), .sm_ent_o(sm_ent_o), .sm_done_i(sm_done_i), .sm_err_i(sm_err_i),
      .sm_rdata_i(sm_rdata_i), .ss_sel_i(ss_sel), .ss_write_i(ss_write), .ss_ent_i(ss_ent),
      .ss_ok_o(ss_ok_o), .ss_retract_o(ss_retract_o), .ss_rvalid_o(ss_rvalid_o),
      .ss_rdata_o(ss_rdata_o), .mem_req_o(mem_req_o), .mem_ent_o(mem_ent_o),
      .mem_done_i(mem_done_i), .mem_rdata_i(mem_rdata_i));
   sbb_far_model sbb_far_model_i (.sclk_i(sclk_i), .mclk_i(mclk_i), .slow_i(slow), .err_i(err),
      .sm_req_i(sm_req_o), .sm_ent_i(sm_ent_o), .sm_done_o(sm_done_i), .sm_err_o(sm_err_i),
      .sm_rdata_o(sm_rdata_i), .mem_req_i(mem_req_o), .mem_ent_i(mem_ent_o),
      .mem_done_o(mem_done_i), .mem_rdata_o(mem_rdata_i));
   always @(negedge mclk_i) if (cpu_abort_o === 1'b1) n_abort++;
   always @(negedge sclk_i) begin
      sm_prev <= sm_req_o;
      if (sm_req_o === 1'b1 && sm_prev !== 1'b1) got_q.push_back(sm_ent_o);
   end
   task chk(input logic [SBB_ENTRY_W-1:0] seen, input logic [SBB_ENTRY_W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function sbb_entry_s rnd_ent(input logic w);
      logic [95:0] raw;
      raw = {$random(seed), $random(seed), $random(seed)};
      rnd_ent = raw[SBB_ENTRY_W-1:0];
      rnd_ent.ctrl[0] = w;
      rnd_ent.addr[1:0] = 2'b00;
   endfunction : rnd_ent
   // Outbound read data is the inverted address
   function logic [SBB_DW-1:0] exp_rd(input sbb_entry_s x);
      return ~x.addr;
   endfunction : exp_rd
   task cpu_op(input logic w, input sbb_entry_s x, output int cnt, output logic [SBB_DW-1:0] rd);
      cnt = 0;
      @(posedge mclk_i);
      cpu_req <= 1'b1;
      cpu_write <= w;
      cpu_ent <= x;
      do begin
         @(negedge mclk_i);
         cnt++;
      end while (cpu_ready_o !== 1'b1 && cnt < 400);
      chk(cpu_ready_o, 1'b1);
      rd = cpu_rdata_o;
      @(posedge mclk_i);
      cpu_req <= 1'b0;
   endtask : cpu_op
   // Result: 1 accepted, 2 retracted, 0 neither
   task ss_op(input logic w, input sbb_entry_s x, output int res, output logic [SBB_DW-1:0] rd);
      int c;
      res = 0;
      c = 0;
      @(posedge sclk_i);
      ss_sel <= 1'b1;
      ss_write <= w;
      ss_ent <= x;
      #1;
      if (w) begin
         res = (ss_ok_o === 1'b1) ? 1 : ((ss_retract_o === 1'b1) ? 2 : 0);
         @(posedge sclk_i);
      end else begin
         while (ss_rvalid_o !== 1'b1 && c < 300) begin
            if (ss_retract_o === 1'b1) res = 2;
            @(posedge sclk_i);
            #1;
            c++;
         end
         if (res == 0 && c < 300) res = 1;
      end
      rd = ss_rdata_o;
      ss_sel <= 1'b0;
   endtask : ss_op
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   initial begin
      #2000000;
      n_errors++;
      end_sim;
   end
   initial begin
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      srst_n_i <= 1'b1;
      repeat (4) @(posedge sclk_i);
      for (int i = 0; i < 4; i++) begin
         e = rnd_ent(1'b1);
         exp_q.push_back(e);
         cpu_op(1'b1, e, n, d);
         chk(n == 1, i == 0);
      end
      k = 0;
      // Last write must finish before errors are injected
      while ((got_q.size() < 4 || sm_req_o !== 1'b0) && k < 600) begin @(posedge mclk_i); k++; end
      for (int i = 0; i < 4; i++) chk(got_q[i], exp_q[i]);
      $display("test posted writes done");
      err <= 1'b1;
      cpu_op(1'b1, rnd_ent(1'b1), n, d);
      k = 0;
      while (n_abort == 0 && k < 300) begin @(posedge mclk_i); k++; end
      repeat (20) @(posedge mclk_i);
      chk(n_abort, 1);
      err <= 1'b0;
      slow <= 1'b0;
      e = rnd_ent(1'b0);
      cpu_op(1'b0, e, n, d);
      chk(d, exp_rd(e));
      chk(n > 2, 1'b1);
      $display("test abort and read done");
      slow <= 1'b1;
      e = rnd_ent(1'b1);
      e2 = rnd_ent(1'b1);
      e2.addr[5:2] = e.addr[5:2] + 4'h1;
      ss_op(1'b1, e, r, d);
      chk(r, 1);
      ss_op(1'b1, e2, r, d);
      chk(r, 2);
      k = 0;
      while (r != 1 && k < 60) begin ss_op(1'b1, e2, r, d); k++; end
      chk(r, 1);
      e.ctrl[0] = 1'b0;
      e2.ctrl[0] = 1'b0;
      // Read the word whose write is still queued
      ss_op(1'b0, e2, r, d);
      chk({r, d}, {32'd1, e2.data});
      $display("test inbound done");
      slow <= 1'b0;
      fork
         cpu_op(1'b0, e, n, d);
         ss_op(1'b0, e, r, d2);
      join
      chk(d, exp_rd(e));
      chk(d2, e.data);
      $display("test concurrent paths done");
      end_sim;
   end
endmodule : sbb_bridge_test
